// >>> tw_master.sv
// Hardware-sequenced two-wire bus master with byte FIFOs
// Overview of operation
// [RL1] Four transfer kinds: read, write, read then write, write then read.
// [RL2] Read transfer fetches one to 16 bytes, then stops.
// [RL3] Write transfer sends one to 16 bytes, then stops.
// [RL4] Read-then-write reads up to 16, repeated start, writes up to 16.
// [RL5] Write-then-read writes up to 16, repeated start, reads up to 16.
// [RL6] Bus clock selectable at 100, 400 or 800 kHz.
// [RL7] Extra 1 MHz bus clock setting, high-speed slaves not guaranteed.
// [RL8] No arbitration; this master assumes it owns the bus.
// [RL9] Slaves must not stretch the clock; stretching is not honoured.
// [RL10] Both lines driven open-drain only; only SDA is sampled, the SCL input is unused.
// [RL11] Whole transfer sequenced in hardware after one start command.
// [RL12] Outgoing and incoming bytes held in buffers per direction.
// [RL13] Done flag on completion; error flag on any missing acknowledge.
`include "tw_consts.svh"
module tw_master #(
   parameter int FIFO_DEPTH = `TW_FIFO_DEPTH
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire tw_pkg::tw_cmd_s cmd_in,
   input wire logic start_in,
   output logic busy_out,
   output logic done_out,
   output logic nack_err_out,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out,
   output logic [7:0] rx_data_out,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out
);
   if (FIFO_DEPTH < `TW_MAX_BYTES) begin : g_bad_depth
      $error("tw_master needs a FIFO deep enough for one full segment");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} tw_state_e;

   localparam logic [`TW_DIV_W-1:0] QTR0 = `TW_DIV_W'(`TW_QTR_CYC(`TW_RATE0_KHZ) - 1);
   localparam logic [`TW_DIV_W-1:0] QTR1 = `TW_DIV_W'(`TW_QTR_CYC(`TW_RATE1_KHZ) - 1);
   localparam logic [`TW_DIV_W-1:0] QTR2 = `TW_DIV_W'(`TW_QTR_CYC(`TW_RATE2_KHZ) - 1);
   localparam logic [`TW_DIV_W-1:0] QTR3 = `TW_DIV_W'(`TW_QTR_CYC(`TW_RATE3_KHZ) - 1);

   tw_state_e st_q;
   tw_pkg::tw_cmd_s cmd_q;
   logic seg_q;
   logic [3:0] bit_q;
   logic [1:0] qtr_q;
   logic [`TW_DIV_W-1:0] div_q;
   logic [7:0] sh_q;
   logic is_addr_q;
   logic [3:0] left_q;
   logic nack_q;
   logic scl_low_q;
   logic sda_low_q;
   logic done_q;
   logic err_q;

   logic [7:0] tx_fifo_data;
   logic tx_fifo_valid;
   logic rx_fifo_ready;
   logic tx_pop_w;
   logic rx_push_w;

   // Buffers per direction; both ports give back-pressure [RL12]
   tw_fifo #(.W(`TW_BYTE_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .wr_data_in(tx_data_in),
      .wr_valid_in(tx_valid_in),
      .wr_ready_out(tx_ready_out),
      .rd_data_out(tx_fifo_data),
      .rd_valid_out(tx_fifo_valid),
      .rd_ready_in(tx_pop_w)
   );
   tw_fifo #(.W(`TW_BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .mclk_in(mclk_in),
      .resetn_in(resetn_in),
      .wr_data_in(sh_q),
      .wr_valid_in(rx_push_w),
      .wr_ready_out(rx_fifo_ready),
      .rd_data_out(rx_data_out),
      .rd_valid_out(rx_valid_out),
      .rd_ready_in(rx_ready_in)
   );

   // Segment direction per transfer kind [RL1] [RL4] [RL5]
   wire two_seg_w = (cmd_q.kind == tw_pkg::TW_RD_WR) || (cmd_q.kind == tw_pkg::TW_WR_RD);
   wire cur_rd_w = (cmd_q.kind == tw_pkg::TW_READ) ||
                   (cmd_q.kind == tw_pkg::TW_RD_WR && !seg_q) ||
                   (cmd_q.kind == tw_pkg::TW_WR_RD && seg_q);
   wire [3:0] seg_cnt_w = cur_rd_w ? cmd_q.rd_cnt_m1 : cmd_q.wr_cnt_m1; // [RL2] [RL3]
   wire drive_byte_w = is_addr_q || !cur_rd_w;

   // Quarter-bit divider; slowest rate fits the divider width [RL6] [RL7]
   // Idle follows the incoming rate so the first quarter already has its own length
   wire [1:0] rate_w = (st_q == ST_IDLE) ? cmd_in.rate : cmd_q.rate;
   wire [`TW_DIV_W-1:0] qtr_reload_w =
      (rate_w == tw_pkg::TW_100K) ? QTR0 :
      (rate_w == tw_pkg::TW_400K) ? QTR1 :
      (rate_w == tw_pkg::TW_800K) ? QTR2 : QTR3;
   wire tick_w = (st_q != ST_IDLE) && (div_q == '0);

   wire in_bit_w = (st_q == ST_BIT) && tick_w && (qtr_q == 2'h3);
   wire end_rd_data_w = in_bit_w && !drive_byte_w && (bit_q == 4'h7);
   wire end_byte_w = in_bit_w && (bit_q == `TW_ACK_BIT);
   wire nack_stop_w = drive_byte_w && nack_q;
   wire need_tx_w = !nack_stop_w && !cur_rd_w && (is_addr_q || left_q != 4'h0);
   // Stalls freeze the bus with SCL released and no edges; a slave stretch is not seen [RL9]
   wire stall_w = (end_rd_data_w && !rx_fifo_ready) || (end_byte_w && need_tx_w && !tx_fifo_valid);
   assign rx_push_w = end_rd_data_w && rx_fifo_ready;
   assign tx_pop_w = end_byte_w && need_tx_w && tx_fifo_valid;
   wire step_w = tick_w && !stall_w;

   // Open-drain only: data is always zero, enable pulls low [RL10]
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe_out = scl_low_q;
   assign sda_oe_out = sda_low_q;
   assign busy_out = (st_q != ST_IDLE);
   assign done_out = done_q;
   assign nack_err_out = err_q;

   always_ff @(posedge mclk_in) begin
      if (!resetn_in || st_q == ST_IDLE || tick_w) begin
         div_q <= qtr_reload_w;
      end else begin
         div_q <= div_q - 1'b1;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         qtr_q <= 2'h0;
      end else if (st_q == ST_IDLE) begin
         qtr_q <= 2'h0;
      end else if (step_w) begin
         qtr_q <= qtr_q + 2'h1;
      end
   end

   // Single master: lines are driven without any arbitration check [RL8]
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         st_q <= ST_IDLE;
         cmd_q <= '0;
         seg_q <= 1'b0;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         is_addr_q <= 1'b0;
         left_q <= 4'h0;
         nack_q <= 1'b0;
         scl_low_q <= 1'b0;
         sda_low_q <= 1'b0;
         done_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
               scl_low_q <= 1'b0;
               sda_low_q <= 1'b0;
               if (start_in) begin // [RL11]
                  cmd_q <= cmd_in;
                  seg_q <= 1'b0;
                  done_q <= 1'b0;
                  err_q <= 1'b0;
                  st_q <= ST_START;
               end
            end
            ST_START: begin
               // Same sequence serves as repeated start between segments
               if (step_w) begin
                  case (qtr_q)
                     2'h0: sda_low_q <= 1'b0;
                     2'h1: scl_low_q <= 1'b0;
                     2'h2: sda_low_q <= 1'b1;
                     default: begin
                        scl_low_q <= 1'b1;
                        sh_q <= {cmd_q.addr, cur_rd_w};
                        is_addr_q <= 1'b1;
                        bit_q <= 4'h0;
                        st_q <= ST_BIT;
                     end
                  endcase
               end
            end
            ST_BIT: begin
               if (step_w) begin
                  case (qtr_q)
                     2'h0: begin
                        if (bit_q != `TW_ACK_BIT) begin
                           sda_low_q <= drive_byte_w && !sh_q[7];
                        end else begin
                           // Master acks all read bytes but the last [RL2] [RL5]
                           sda_low_q <= !drive_byte_w && (left_q != 4'h0);
                        end
                     end
                     2'h1: scl_low_q <= 1'b0;
                     2'h2: begin
                        if (bit_q != `TW_ACK_BIT) begin
                           sh_q <= {sh_q[6:0], sda_in};
                        end else begin
                           nack_q <= sda_in;
                        end
                     end
                     default: begin
                        scl_low_q <= 1'b1;
                        if (bit_q != `TW_ACK_BIT) begin
                           bit_q <= bit_q + 4'h1;
                        end else begin
                           bit_q <= 4'h0;
                           if (nack_stop_w) begin
                              err_q <= 1'b1; // [RL13]
                              st_q <= ST_STOP;
                           end else if (is_addr_q) begin
                              is_addr_q <= 1'b0;
                              left_q <= seg_cnt_w;
                              if (!cur_rd_w) begin
                                 sh_q <= tx_fifo_data;
                              end
                           end else if (left_q != 4'h0) begin
                              left_q <= left_q - 4'h1; // [RL2] [RL3]
                              if (!cur_rd_w) begin
                                 sh_q <= tx_fifo_data;
                              end
                           end else if (two_seg_w && !seg_q) begin
                              seg_q <= 1'b1; // [RL4] [RL5]
                              st_q <= ST_START;
                           end else begin
                              st_q <= ST_STOP;
                           end
                        end
                     end
                  endcase
               end
            end
            ST_STOP: begin
               if (step_w) begin
                  case (qtr_q)
                     2'h0: sda_low_q <= 1'b1;
                     2'h1: scl_low_q <= 1'b0;
                     2'h2: sda_low_q <= 1'b0;
                     default: begin
                        done_q <= 1'b1; // [RL13]
                        st_q <= ST_IDLE;
                     end
                  endcase
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
endmodule // tw_master

// >>> tw_consts.svh
// Timing constants and field widths for the two-wire master
`ifndef TW_CONSTS_SVH
`define TW_CONSTS_SVH
`define TW_CLK_MHZ 200
`define TW_RATE0_KHZ 100
`define TW_RATE1_KHZ 400
`define TW_RATE2_KHZ 800
`define TW_RATE3_KHZ 1000
// Quarter of one bus clock period in system clocks, rounded down
`define TW_QTR_CYC(k) ((`TW_CLK_MHZ * 1000) / (4 * (k)))
`define TW_DIV_W 9
`define TW_MAX_BYTES 16
`define TW_FIFO_DEPTH 32
`define TW_BYTE_W 8
`define TW_ACK_BIT 4'h8
`endif

// >>> tw_pkg.sv
// Types shared by the two-wire master and its bench
package tw_pkg;
   typedef enum logic [1:0] {TW_READ, TW_WRITE, TW_RD_WR, TW_WR_RD} tw_kind_e;
   typedef enum logic [1:0] {TW_100K, TW_400K, TW_800K, TW_1M} tw_rate_e;
   typedef struct packed {
      tw_kind_e kind;
      tw_rate_e rate;
      logic [6:0] addr;
      logic [3:0] rd_cnt_m1;
      logic [3:0] wr_cnt_m1;
   } tw_cmd_s;
endpackage

// >>> tw_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
module tw_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 32
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [W-1:0] wr_data_in,
   input wire logic wr_valid_in,
   output logic wr_ready_out,
   output logic [W-1:0] rd_data_out,
   output logic rd_valid_out,
   input wire logic rd_ready_in
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("tw_fifo depth must be a power of two of at least 2");
   end
   logic [W-1:0] mem_q [DEPTH];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;
   wire full_w = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire empty_w = (wp_q == rp_q);
   wire push_w = wr_valid_in && !full_w;
   wire pop_w = rd_ready_in && !empty_w;
   assign wr_ready_out = !full_w;
   assign rd_valid_out = !empty_w;
   assign rd_data_out = mem_q[rp_q[AW-1:0]];
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (push_w) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop_w) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
   // Storage needs no reset; empty flags guard stale entries
   always_ff @(posedge mclk_in) begin
      if (push_w) begin
         mem_q[wp_q[AW-1:0]] <= wr_data_in;
      end
   end
endmodule // tw_fifo

// >>> tw_master_checker.sv
// Port assertions for the two-wire master
module tw_master_checker #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire tw_pkg::tw_cmd_s cmd_in,
   input wire logic start_in,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic nack_err_out,
   input wire logic [7:0] rx_data_out,
   input wire logic rx_valid_out,
   input wire logic rx_ready_in,
   input wire logic scl_oe_out,
   input wire logic sda_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] hi_q;
   logic seen_q;
   tw_pkg::tw_rate_e rate_q;
   wire logic take = start_in && !busy_out;
   // SCL high time is two quarters; first rise of a transfer skipped, idle time precedes it
   wire logic [15:0] half = rate_q == tw_pkg::TW_100K ? 16'h03E8 :
      rate_q == tw_pkg::TW_400K ? 16'h00FA : rate_q == tw_pkg::TW_800K ? 16'h007C : 16'h0064;
   always_ff @(posedge mclk_in) begin
      hi_q <= (scl_oe_out || !resetn_in) ? 16'h0000 : hi_q + 16'h0001;
      seen_q <= resetn_in && !take && (seen_q || scl_oe_out);
      if (take) rate_q <= cmd_in.rate;
   end
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_take; take; endsequence
   sequence s_quiet; (!scl_oe_out && !sda_oe_out) [*8]; endsequence
   chk_busy_follows: assert property (s_take |=> busy_out) else $error("busy late");
   chk_flags_cleared: assert property (s_take |=> !done_out && !nack_err_out)
      else $error("flags not cleared");
   chk_start_quiet: assert property (s_take |=> s_quiet) else $error("lines early");
   chk_done_at_end: assert property ($fell(busy_out) |-> done_out && !scl_oe_out && !sda_oe_out)
      else $error("bad end");
   chk_err_holds: assert property (!take && nack_err_out |=> nack_err_out)
      else $error("error flag lost");
   chk_idle_free: assert property (!busy_out |-> !scl_oe_out && !sda_oe_out)
      else $error("line pulled while idle");
   chk_scl_high: assert property ($rose(scl_oe_out) && seen_q |-> hi_q == half)
      else $error("wrong bus clock");
   chk_rx_holds: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out &&
      $stable(rx_data_out)) else $error("rx byte lost");
endmodule // tw_master_checker

// >>> tw_slave_model.sv
// Behavioural two-wire slave answering one address
module tw_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe_out,
   output logic [7:0] wr_byte_out,
   output logic wr_tgl_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh, td, nxt;
   logic act, adr, rd;
   int nb;
   // Only SDA is ever pulled: SCL is never held low for wait states
   initial begin
      sda_oe_out = 1'h0;
      wr_tgl_out = 1'h0;
      act = 1'h0;
      nxt = 8'h5A;
   end
   always @(negedge sda_in) if (scl_in === 1'h1) begin
      act = 1'h1;
      adr = 1'h1;
      nb = 0;
      sda_oe_out = 1'h0;
   end
   always @(posedge sda_in) if (scl_in === 1'h1) act = 1'h0;
   always @(posedge scl_in) if (act) begin
      if (nb < 8) sh = {sh[6:0], sda_in};
      else if (rd && sda_in === 1'h1) act = 1'h0;
      nb++;
   end
   // Unknown address is not acknowledged, the only refusal it makes
   always @(negedge scl_in) if (act) begin
      if (nb == 8 && adr) begin
         adr = 1'h0;
         rd = sh[0];
         sda_oe_out = sh[7:1] == ADDR;
         act = sh[7:1] == ADDR;
      end else if (nb == 8) begin
         sda_oe_out = !rd;
         wr_byte_out = sh;
         if (!rd) wr_tgl_out = !wr_tgl_out;
      end else if (nb == 9) begin
         nb = 0;
         sda_oe_out = 1'h0;
         td = nxt;
         if (rd) nxt++;
      end
      if (rd && !adr && nb < 8) sda_oe_out = !td[7 - nb];
   end
endmodule // tw_slave_model

// >>> testbench.sv
// Self-checking bench for the two-wire master
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [6:0] SLV = 7'h2A;
   logic mclk_in = 1'h0, resetn_in = 1'h0, start_in = 1'h0, tx_valid_in = 1'h0;
   logic rx_ready_in = 1'h0, tgl, slv_oe, bq = 1'h0, scl_d, sda_d;
   logic busy_out, done_out, nack_err_out, tx_ready_out, rx_valid_out, scl_oe_out, sda_oe_out;
   tw_pkg::tw_cmd_s cmd_in = '0;
   logic [7:0] tx_data_in = 8'h00, rx_data_out, wr_b, rd_i = 8'h5A;
   logic [7:0] exp_rx[$], exp_wr[$];
   logic [1:0] exp_st[$], e;
   logic [3:0] rc, wc;
   logic [15:0] lfsr = 16'h3B8C;
   int fails = 0, num_checks = 0, i, j;
   wire logic scl_w = !scl_oe_out;
   wire logic sda_w = !(sda_oe_out || slv_oe);
   tw_master #(.FIFO_DEPTH(32)) uut (.mclk_in(mclk_in), .resetn_in(resetn_in), .cmd_in(cmd_in),
      .start_in(start_in), .busy_out(busy_out), .done_out(done_out), .nack_err_out(nack_err_out),
      .tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
      .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in),
      .scl_in(scl_w), .scl_out(scl_d), .scl_oe_out(scl_oe_out), .sda_in(sda_w),
      .sda_out(sda_d),
      .sda_oe_out(sda_oe_out));
   tw_slave_model #(.ADDR(SLV)) slv (.scl_in(scl_w), .sda_in(sda_w), .sda_oe_out(slv_oe),
      .wr_byte_out(wr_b), .wr_tgl_out(tgl));
   initial forever #2.5 mclk_in = !mclk_in;
   function automatic logic [15:0] step(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // An unknown result or a missing note never counts as a match
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] x);
      logic bad;
      bad = (g !== x) || $isunknown(g);
      num_checks++;
      if (bad) begin
         fails++;
         $display("wrong value at %0t: byte %h not %h", $time, g, x);
      end
   endtask
   task automatic cmp_flag(input logic g, input logic x);
      logic bad;
      bad = (g !== x) || $isunknown(g);
      num_checks++;
      if (bad) begin
         fails++;
         $display("wrong value at %0t: flag %b not %b", $time, g, x);
      end
   endtask
   task automatic tick();
      @(posedge mclk_in);
      #1;
   endtask
   task automatic hang();
      cmp_flag(1'h1, 1'h0);
      report_and_stop();
   endtask
   // Valid stays up between pushes so no input is driven twice in one step
   task automatic push(input logic [7:0] d, input logic keep);
      tx_data_in = d;
      tx_valid_in = 1'h1;
      for (int n = 0; tx_ready_out !== 1'h1; n++) begin
         if (n == 900) hang();
         tick();
      end
      tick();
      if (keep) exp_wr.push_back(d);
   endtask
   task automatic run(input tw_pkg::tw_kind_e k, input tw_pkg::tw_rate_e r, input logic [6:0] a);
      cmd_in = '{kind: k, rate: r, addr: a, rd_cnt_m1: rc, wr_cnt_m1: wc};
      start_in = 1'h1;
      tick();
      start_in = 1'h0;
      exp_st.push_back({1'h1, a != SLV});
      for (int n = 0; a == SLV && k != tw_pkg::TW_WRITE && n <= rc; n++) exp_rx.push_back(rd_i++);
      for (int n = 0; busy_out !== 1'h0; n++) begin
         if (n == 40000) hang();
         tick();
      end
      tick();
   endtask
   always @(posedge mclk_in) begin
      lfsr = step(lfsr);
      if (rx_valid_out === 1'h1 && rx_ready_in === 1'h1)
         cmp_byte(rx_data_out, exp_rx.size() ? exp_rx.pop_front() : 8'hxx);
      #1 rx_ready_in = lfsr[0] | lfsr[5];
   end
   always @(tgl) if ($time > 0)
      cmp_byte(wr_b, exp_wr.size() ? exp_wr.pop_front() : 8'hxx);
   always @(negedge mclk_in) begin
      if (bq === 1'h1 && busy_out === 1'h0) begin
         e = exp_st.size() ? exp_st.pop_front() : 2'hx;
         cmp_flag(done_out, e[1]);
         cmp_flag(nack_err_out, e[0]);
      end
      bq = busy_out;
   end
   initial begin
      repeat (4) tick();
      resetn_in = 1'h1;
      rc = 4'h0;
      wc = 4'hF;
      for (i = 0; i < 4; i++) run(tw_pkg::TW_READ, tw_pkg::tw_rate_e'(i), 7'h13);
      $display("rates test done");
      for (i = 0; i < 32; i++) push(8'(lfsr), i < 16);
      tick();
      cmp_flag(tx_ready_out, 1'h0);
      tx_valid_in = 1'h0;
      run(tw_pkg::TW_WRITE, tw_pkg::TW_1M, SLV);
      resetn_in = 1'h0;
      repeat (4) tick();
      resetn_in = 1'h1;
      cmp_flag(tx_ready_out, 1'h1);
      $display("fill test done");
      for (i = 0; i < 4; i += 1 + (i == 0)) begin
         wc = {3'h0, lfsr[9]};
         rc = (i == 0) ? 4'h0 : {3'h0, lfsr[4]};
         for (j = 0; i > 1 && j <= wc; j++) push(8'(lfsr), 1'h1);
         tx_valid_in = 1'h0;
         run(tw_pkg::tw_kind_e'(i), tw_pkg::TW_1M, SLV);
      end
      cmp_flag(scl_d || sda_d, 1'h0);
      $display("kinds test done");
      for (i = 0; i < 300 && exp_rx.size() + exp_wr.size() + exp_st.size() > 0; i++) tick();
      if (i == 300) cmp_flag(1'h1, 1'h0);
      report_and_stop();
   end
endmodule // testbench
bind tw_master tw_master_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk (.mclk_in(mclk_in),
   .resetn_in(resetn_in), .cmd_in(cmd_in), .start_in(start_in), .busy_out(busy_out),
   .done_out(done_out), .nack_err_out(nack_err_out), .rx_data_out(rx_data_out),
   .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in), .scl_oe_out(scl_oe_out),
   .sda_oe_out(sda_oe_out));
